// *** logic/dfcs_pkg.sv ***
/*
 * Constants for the fieldbus command and state word block:
 * bit positions of both words, reset values, reference levels
 * and watchdog timing.
 * Assumes levels in units of 0.01 percent and a 20 MHz clock.
 */
package dfcs_pkg;
    // Word width
    localparam int W = 16;

    // Command word bit positions
    localparam int CMD_CHARGE   = 0;
    localparam int CMD_CLOSE_EN = 1;
    localparam int CMD_RESTART  = 2;
    localparam int CMD_RUN      = 3;
    localparam int CMD_FLOAT    = 4;
    localparam int CMD_DROOP    = 5;
    localparam int CMD_PWR      = 6;
    localparam int CMD_ACK      = 7;
    localparam int CMD_REF_LO   = 8;
    localparam int CMD_REF_HI   = 9;
    localparam int CMD_FB_CTRL  = 10;
    localparam int CMD_TOGGLE   = 11;

    // State word bit positions
    localparam int SB_READY_ON  = 0;
    localparam int SB_READY_RUN = 1;
    localparam int SB_RUNNING   = 2;
    localparam int SB_FAULT     = 3;
    localparam int SB_RUN_EN    = 4;
    localparam int SB_QSTOP_N   = 5;
    localparam int SB_BRK_OK    = 6;
    localparam int SB_WARN      = 7;
    localparam int SB_ON_TARGET = 8;
    localparam int SB_FB_ACT    = 9;
    localparam int SB_ABOVE     = 10;
    localparam int SB_RSV_LO    = 11;
    localparam int SB_RSV_HI    = 13;
    localparam int SB_CHARGING  = 14;
    localparam int SB_ECHO      = 15;

    // Reset values
    localparam logic [W-1:0] CMD_RESET  = 16'h0000;
    localparam logic [W-1:0] STAT_RESET = 16'h0000;
    localparam logic [W-1:0] CNT_ZERO   = 16'h0000;
    localparam logic [W-1:0] CNT_ONE    = 16'h0001;
    localparam logic [W-1:0] CNT_MAX    = 16'hFFFF;

    // Reference levels in 0.01 percent
    localparam logic [W-1:0] REF_LVL1    = 16'h2AF8;
    localparam logic [W-1:0] REF_LVL2    = 16'h2CEC;
    localparam logic [W-1:0] REF_LVL3    = 16'h2EE0;
    localparam logic [W-1:0] FB_REF_MIN  = 16'h1388;
    localparam logic [W-1:0] PWR_REDUCED = 16'h01F4;

    // Reference select codes, bit 9 high, bit 8 low
    localparam logic [1:0] SEL_BUS  = 2'h0;
    localparam logic [1:0] SEL_LVL1 = 2'h1;
    localparam logic [1:0] SEL_LVL2 = 2'h2;
    localparam logic [1:0] SEL_LVL3 = 2'h3;

    // Watchdog time unit
    localparam int CLK_HZ      = 20_000_000;
    localparam int WD_UNIT_US  = 1000;
    localparam int WD_UNIT_CYC = CLK_HZ / 1_000_000 * WD_UNIT_US;
endpackage

// *** logic/dfcs_top.sv ***
/*
 * Fieldbus command word decoder and state word builder for a grid
 * converter drive, with watchdog toggle supervision.
 * Assumes all drive status inputs come from logic on clk, and the
 * command word is written by a one-cycle strobe on the same clock.
 */
// Behaviour
// - Bit 0 low opens breaker or aborts precharge; high requests precharge.
// - Bus precharge needs charge output assigned and bus control place.
// - Bit 1 permits automatic breaker closing after charging.
// - Bit 2 low makes a new charge wait for DC link at zero.
// - Start only on rising bit 3; stop while low; held high never restarts.
// - Bit 4 low enables floating reference; bit 5 high selects droop one.
// - Bit 6 low clamps power to fixed reduced limit, else parameter limit.
// - Faults acknowledged only on rising edge of bit 7.
// - Bits 8 and 9 select bus reference or one of three fixed levels.
// - Bus reference used only if bus control and above threshold.
// - Bit 10 low ignores command word; drop while running coasts.
// - Toggle stalled beyond delay gives fault; zero delay disables.
// - State bit 0 high with no fault, run enable, no forced open, no stop.
// - State bit 1 high with bit 0, DC ready, close command and feedback.
// - State bits 2, 3, 7 show running, fault and warning.
// - State bit 4 shows the run enable input alone.
// - State bit 5 low while quick stop active.
// - State bit 6 high when breaker status and request agree.
// - State bits 8, 9, 10 show on target, bus control, above level.
// - State bit 14 shows DC charging output active.
// - State bit 15 echoes last received bit 11.
`timescale 1ns/1ns
module dfcs_top #(
    parameter int unsigned WD_UNIT_CYCLES = dfcs_pkg::WD_UNIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        cmd_we,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic      [15:0] state_word,
    input  wire logic        charge_do_assigned,
    input  wire logic        control_place_bus,
    input  wire logic        local_start,
    input  wire logic        fault_in,
    input  wire logic        warning_in,
    input  wire logic        run_enable_in,
    input  wire logic        breaker_forced_open,
    input  wire logic        quick_stop,
    input  wire logic        dc_link_ready,
    input  wire logic        dc_link_zero,
    input  wire logic        breaker_feedback,
    input  wire logic        breaker_internal,
    input  wire logic        modulating,
    input  wire logic        link_on_target,
    input  wire logic        link_upper_level,
    input  wire logic [15:0] bus_link_reference,
    input  wire logic [15:0] parameter_link_reference,
    input  wire logic [15:0] parameter_power_limit,
    input  wire logic [15:0] toggle_timeout_setting,
    output logic             link_precharge_cmd,
    output logic             main_breaker_open,
    output logic             main_breaker_close,
    output logic             run_cmd,
    output logic             start_pulse,
    output logic             fault_ack_pulse,
    output logic             coast_stop_pulse,
    output logic             floating_link_reference,
    output logic             link_droop_select,
    output logic [15:0]      power_limit,
    output logic [15:0]      link_reference,
    output logic             watchdog_fault
);
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] eff;
        logic        fb_prev;
        logic        wait_zero;
        logic        precharge;
        logic        close;
        logic        start;
        logic        ack;
        logic        coast;
        logic [15:0] pwr;
        logic [15:0] ref_out;
        logic [15:0] tick;
        logic [15:0] units;
        logic        wd_fault;
        logic [15:0] stat;
    } dfcs_state_t;

    localparam logic [15:0] UNIT_LAST = 16'(WD_UNIT_CYCLES - 1);

    dfcs_state_t st_ff;
    dfcs_state_t nxt_st;

    // Reference chosen from the select code
    function automatic logic [15:0] dfcs_pick_ref(
        input logic [1:0]  sel,
        input logic        bus_ok,
        input logic [15:0] bus_ref,
        input logic [15:0] par_ref
    );
        case (sel)
            dfcs_pkg::SEL_BUS:  dfcs_pick_ref = bus_ok ? bus_ref : par_ref;
            dfcs_pkg::SEL_LVL1: dfcs_pick_ref = dfcs_pkg::REF_LVL1;
            dfcs_pkg::SEL_LVL2: dfcs_pick_ref = dfcs_pkg::REF_LVL2;
            default:            dfcs_pick_ref = dfcs_pkg::REF_LVL3;
        endcase
    endfunction

    logic       fb_on;
    logic       fb_place;
    logic       fault_any;
    logic [1:0] ref_sel;
    logic       toggled;

    // Next state of the whole block
    always_comb begin
        nxt_st   = st_ff;
        fb_on    = st_ff.cmd[dfcs_pkg::CMD_FB_CTRL];
        fb_place = fb_on & control_place_bus;
        ref_sel  = {st_ff.eff[dfcs_pkg::CMD_REF_HI], st_ff.eff[dfcs_pkg::CMD_REF_LO]};
        toggled  = 1'h0;

        // Command word store; bit 15 kept for readback only
        if (cmd_we) begin
            nxt_st.cmd = cmd_wdata;
        end

        // Effective word follows the bus only under bus control
        if (fb_on) begin
            nxt_st.eff = st_ff.cmd;
        end
        nxt_st.fb_prev = fb_on;

        // Edges against the previously accepted word
        nxt_st.start = fb_on & st_ff.cmd[dfcs_pkg::CMD_RUN]
                       & ~st_ff.eff[dfcs_pkg::CMD_RUN];
        nxt_st.ack   = fb_on & st_ff.cmd[dfcs_pkg::CMD_ACK]
                       & ~st_ff.eff[dfcs_pkg::CMD_ACK];

        // Bus control removed while modulating
        nxt_st.coast = st_ff.fb_prev & ~fb_on & modulating;

        // Restart lock until the DC link has discharged
        if (dc_link_zero) begin
            nxt_st.wait_zero = 1'h0;
        end else if (fb_on & ~st_ff.cmd[dfcs_pkg::CMD_RESTART]) begin
            nxt_st.wait_zero = 1'h1;
        end

        // Precharge from bus bit 0 or from the ordinary start
        if (fb_place & charge_do_assigned) begin
            nxt_st.precharge = st_ff.eff[dfcs_pkg::CMD_CHARGE]
                               & ~st_ff.wait_zero;
        end else begin
            nxt_st.precharge = local_start & ~st_ff.wait_zero;
        end

        // Automatic breaker closing after charging
        nxt_st.close = st_ff.eff[dfcs_pkg::CMD_CHARGE]
                       & st_ff.eff[dfcs_pkg::CMD_CLOSE_EN]
                       & dc_link_ready;

        // Power limit and DC reference
        nxt_st.pwr = st_ff.eff[dfcs_pkg::CMD_PWR] ? parameter_power_limit
                                                 : dfcs_pkg::PWR_REDUCED;
        nxt_st.ref_out = dfcs_pick_ref(ref_sel,
                                       fb_on & (bus_link_reference > dfcs_pkg::FB_REF_MIN),
                                       bus_link_reference,
                                       parameter_link_reference);

        // Watchdog toggle supervision in whole time units
        toggled = cmd_we & (cmd_wdata[dfcs_pkg::CMD_TOGGLE]
                            ^ st_ff.cmd[dfcs_pkg::CMD_TOGGLE]);
        if (toggled | (toggle_timeout_setting == dfcs_pkg::CNT_ZERO)) begin
            nxt_st.tick  = dfcs_pkg::CNT_ZERO;
            nxt_st.units = dfcs_pkg::CNT_ZERO;
        end else if (st_ff.tick == UNIT_LAST) begin
            nxt_st.tick = dfcs_pkg::CNT_ZERO;
            if (st_ff.units != dfcs_pkg::CNT_MAX) begin
                nxt_st.units = st_ff.units + dfcs_pkg::CNT_ONE;
            end
        end else begin
            nxt_st.tick = st_ff.tick + dfcs_pkg::CNT_ONE;
        end
        if ((toggle_timeout_setting != dfcs_pkg::CNT_ZERO)
            & (st_ff.units >= toggle_timeout_setting)) begin
            nxt_st.wd_fault = 1'h1;
        end else if (st_ff.ack) begin
            nxt_st.wd_fault = 1'h0;
        end

        // State word
        fault_any = fault_in | st_ff.wd_fault;
        nxt_st.stat = dfcs_pkg::STAT_RESET;
        nxt_st.stat[dfcs_pkg::SB_READY_ON] = ~fault_any & run_enable_in
                                             & ~breaker_forced_open
                                             & ~quick_stop;
        nxt_st.stat[dfcs_pkg::SB_READY_RUN] = st_ff.eff[dfcs_pkg::CMD_CHARGE]
                                              & dc_link_ready & st_ff.close
                                              & breaker_feedback;
        nxt_st.stat[dfcs_pkg::SB_RUNNING]  = modulating;
        nxt_st.stat[dfcs_pkg::SB_FAULT]    = fault_any;
        nxt_st.stat[dfcs_pkg::SB_WARN]     = warning_in;
        nxt_st.stat[dfcs_pkg::SB_RUN_EN]   = run_enable_in;
        nxt_st.stat[dfcs_pkg::SB_QSTOP_N]  = ~quick_stop;
        nxt_st.stat[dfcs_pkg::SB_BRK_OK]   = ~(breaker_internal ^ st_ff.close);
        nxt_st.stat[dfcs_pkg::SB_ON_TARGET] = link_on_target;
        nxt_st.stat[dfcs_pkg::SB_FB_ACT]   = fb_on;
        nxt_st.stat[dfcs_pkg::SB_ABOVE]    = link_upper_level;
        nxt_st.stat[dfcs_pkg::SB_CHARGING] = st_ff.precharge;
        nxt_st.stat[dfcs_pkg::SB_ECHO]     = st_ff.cmd[dfcs_pkg::CMD_TOGGLE];

        // Reset state
        if (srst) begin
            nxt_st           = '0;
            nxt_st.cmd       = dfcs_pkg::CMD_RESET;
            nxt_st.eff       = dfcs_pkg::CMD_RESET;
            nxt_st.stat      = dfcs_pkg::STAT_RESET;
            nxt_st.pwr       = dfcs_pkg::PWR_REDUCED;
            nxt_st.ref_out   = dfcs_pkg::CNT_ZERO;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // Outputs
    assign cmd_rdata               = st_ff.cmd;
    assign state_word              = st_ff.stat;
    assign link_precharge_cmd      = st_ff.precharge;
    assign main_breaker_open       = ~st_ff.eff[dfcs_pkg::CMD_CHARGE];
    assign main_breaker_close      = st_ff.close;
    assign run_cmd                 = st_ff.eff[dfcs_pkg::CMD_RUN];
    assign start_pulse             = st_ff.start;
    assign fault_ack_pulse         = st_ff.ack;
    assign coast_stop_pulse        = st_ff.coast;
    assign floating_link_reference = ~st_ff.eff[dfcs_pkg::CMD_FLOAT];
    assign link_droop_select       = st_ff.eff[dfcs_pkg::CMD_DROOP];
    assign power_limit             = st_ff.pwr;
    assign link_reference          = st_ff.ref_out;
    assign watchdog_fault          = st_ff.wd_fault;

    // Checks
    default clocking chk_clk @(posedge clk); endclocking
    default disable iff (srst);

    sequence run_held_s;
        st_ff.eff[dfcs_pkg::CMD_RUN] [*2];
    endsequence

    sequence bus_lost_s;
        st_ff.cmd[dfcs_pkg::CMD_FB_CTRL] ##1 !st_ff.cmd[dfcs_pkg::CMD_FB_CTRL];
    endsequence

    start_edge_a: assert property (
        st_ff.start == $rose(st_ff.eff[dfcs_pkg::CMD_RUN]))
        else $error("start pulse not on run edge");

    no_restart_a: assert property (
        run_held_s |-> !st_ff.start)
        else $error("restart while run held");

    ack_edge_a: assert property (
        st_ff.ack == $rose(st_ff.eff[dfcs_pkg::CMD_ACK]))
        else $error("ack pulse not on edge");

    ignore_word_a: assert property (
        !st_ff.cmd[dfcs_pkg::CMD_FB_CTRL] |=> $stable(st_ff.eff))
        else $error("word followed without bus control");

    coast_stop_a: assert property (
        (bus_lost_s ##0 modulating) |=> st_ff.coast)
        else $error("no coast stop");

    ref_level_a: assert property (
        (st_ff.eff[dfcs_pkg::CMD_REF_HI] && st_ff.eff[dfcs_pkg::CMD_REF_LO])
        |=> st_ff.ref_out == dfcs_pkg::REF_LVL3)
        else $error("third level not chosen");

    pwr_clamp_a: assert property (
        !st_ff.eff[dfcs_pkg::CMD_PWR] |=> st_ff.pwr == dfcs_pkg::PWR_REDUCED)
        else $error("power not clamped");

    wd_off_a: assert property (
        (toggle_timeout_setting == dfcs_pkg::CNT_ZERO && !st_ff.wd_fault)
        |=> !st_ff.wd_fault)
        else $error("watchdog fault while disabled");

    echo_bit_a: assert property (
        st_ff.stat[dfcs_pkg::SB_ECHO] == $past(st_ff.cmd[dfcs_pkg::CMD_TOGGLE]))
        else $error("toggle echo wrong");

    reserved_zero_a: assert property (
        st_ff.stat[dfcs_pkg::SB_RSV_HI:dfcs_pkg::SB_RSV_LO] == 3'h0)
        else $error("reserved bits set");

    ready_on_a: assert property (
        st_ff.stat[dfcs_pkg::SB_READY_ON] == $past(~(fault_in | st_ff.wd_fault)
            & run_enable_in & ~breaker_forced_open & ~quick_stop))
        else $error("ready on wrong");

    sequence lock_set_s;
        fb_on && !st_ff.cmd[dfcs_pkg::CMD_RESTART] && !dc_link_zero;
    endsequence

    sequence wd_expired_s;
        (toggle_timeout_setting != dfcs_pkg::CNT_ZERO)
        && (st_ff.units >= toggle_timeout_setting);
    endsequence

    lock_set_a: assert property (
        lock_set_s |=> st_ff.wait_zero)
        else $error("restart lock not set");

    lock_blocks_a: assert property (
        st_ff.wait_zero |=> !st_ff.precharge)
        else $error("precharge while locked");

    charge_abort_a: assert property (
        (!st_ff.eff[dfcs_pkg::CMD_CHARGE] && fb_place && charge_do_assigned)
        |=> !st_ff.precharge)
        else $error("precharge not aborted");

    close_gate_a: assert property (
        !st_ff.eff[dfcs_pkg::CMD_CLOSE_EN] |=> !st_ff.close)
        else $error("breaker closed while inhibited");

    wd_timeout_a: assert property (
        wd_expired_s |=> st_ff.wd_fault)
        else $error("watchdog timeout missed");

    param_ref_a: assert property (
        (ref_sel == dfcs_pkg::SEL_BUS && !fb_on)
        |=> st_ff.ref_out == $past(parameter_link_reference))
        else $error("parameter reference not used");

    fault_bit_a: assert property (
        st_ff.stat[dfcs_pkg::SB_FAULT] == $past(fault_in | st_ff.wd_fault))
        else $error("fault bit wrong");

    charging_bit_a: assert property (
        st_ff.stat[dfcs_pkg::SB_CHARGING] == $past(st_ff.precharge))
        else $error("charging bit wrong");

    ready_run_a: assert property (
        st_ff.stat[dfcs_pkg::SB_READY_RUN]
        |-> $past(st_ff.eff[dfcs_pkg::CMD_CHARGE] & breaker_feedback))
        else $error("ready to run wrong");
endmodule

// *** tb/dfcs_bus_master.sv ***
/*
 * Behavioural fieldbus master that writes command words and keeps the
 * watchdog toggle running.
 * Assumes it shares clk and srst with the block; the bench asks for writes
 * by a one-cycle send request and switches the toggle on and off.
 */
`timescale 1ns/1ns
module dfcs_bus_master #(
    parameter int unsigned TOGGLE_CYC = 4
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        send,
    input  wire logic [15:0] word,
    input  wire logic        toggle_en,
    output logic             cmd_we,
    output logic      [15:0] cmd_wdata,
    output logic             toggle_bit
);
    typedef struct packed {
        logic        we;
        logic [15:0] data;
        logic [15:0] last;
        logic        tog;
        logic [7:0]  cnt;
    } dfcs_mst_t;

    dfcs_mst_t st_ff;
    dfcs_mst_t nxt_st;

    // Bench writes win; otherwise the toggle repeats the last word
    always_comb begin
        nxt_st = st_ff;
        nxt_st.we = 1'b0;
        nxt_st.data = ~st_ff.data; // Idle data never holds the old word
        nxt_st.cnt = (st_ff.cnt == 8'(TOGGLE_CYC - 1)) ? 8'h00 : st_ff.cnt + 8'h01;
        if (send) begin
            nxt_st.we = 1'b1;
            nxt_st.last = word;
            nxt_st.data = {word[15:12], st_ff.tog, word[10:0]};
        end else if (toggle_en && st_ff.cnt == 8'(TOGGLE_CYC - 1)) begin
            nxt_st.we = 1'b1;
            nxt_st.tog = ~st_ff.tog;
            nxt_st.data = {st_ff.last[15:12], ~st_ff.tog, st_ff.last[10:0]};
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_ff <= srst ? '0 : nxt_st;
    end

    assign cmd_we     = st_ff.we;
    assign cmd_wdata  = st_ff.data;
    assign toggle_bit = st_ff.tog;
endmodule

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the command and state word block.
 * Assumes the bus master model sits between the bench and the block;
 * the watchdog unit is shortened to four clock cycles.
 */
`timescale 1ns/1ns
module tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        send = 1'b0;
    logic        toggle_en = 1'b0;
    logic [15:0] word = 16'h0000;
    logic        cmd_we;
    logic [15:0] cmd_wdata;
    logic        toggle_bit;
    logic [15:0] cmd_rdata;
    logic [15:0] state_word;
    logic [7:0]  st_in = 8'h00;
    logic        chg_do = 1'b1;
    logic        place_bus = 1'b1;
    logic        local_start = 1'b0;
    logic        dc_ready = 1'b0;
    logic        dc_zero = 1'b1;
    logic        brk_fb = 1'b0;
    logic        brk_int = 1'b0;
    logic [15:0] bus_ref = 16'h1389;
    logic [15:0] wd_set = 16'h0000;
    logic        pre;
    logic        brk_open;
    logic        brk_close;
    logic        run;
    logic        start_p;
    logic        ack_p;
    logic        coast_p;
    logic        float_ref;
    logic        droop;
    logic [15:0] pwr;
    logic [15:0] ref_out;
    logic        wd_fault;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n_start = 0;
    int          n_ack = 0;
    int          n_coast = 0;
    logic [15:0] exp_s;
    logic [15:0] levels [4] = '{16'h1234, dfcs_pkg::REF_LVL1, dfcs_pkg::REF_LVL2,
                               dfcs_pkg::REF_LVL3};

    dfcs_bus_master #(.TOGGLE_CYC(4)) master (.clk(clk), .srst(srst), .send(send),
        .word(word), .toggle_en(toggle_en), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
        .toggle_bit(toggle_bit));

    dfcs_top #(.WD_UNIT_CYCLES(4)) dut (.clk(clk), .srst(srst), .cmd_we(cmd_we),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .state_word(state_word),
        .charge_do_assigned(chg_do), .control_place_bus(place_bus),
        .local_start(local_start), .fault_in(st_in[7]), .warning_in(st_in[6]),
        .run_enable_in(st_in[5]), .breaker_forced_open(st_in[4]), .quick_stop(st_in[3]),
        .dc_link_ready(dc_ready), .dc_link_zero(dc_zero), .breaker_feedback(brk_fb),
        .breaker_internal(brk_int), .modulating(st_in[2]), .link_on_target(st_in[1]),
        .link_upper_level(st_in[0]), .bus_link_reference(bus_ref),
        .parameter_link_reference(16'h1234), .parameter_power_limit(16'h0BB8),
        .toggle_timeout_setting(wd_set), .link_precharge_cmd(pre),
        .main_breaker_open(brk_open), .main_breaker_close(brk_close), .run_cmd(run),
        .start_pulse(start_p), .fault_ack_pulse(ack_p), .coast_stop_pulse(coast_p),
        .floating_link_reference(float_ref), .link_droop_select(droop),
        .power_limit(pwr), .link_reference(ref_out), .watchdog_fault(wd_fault));

    // Clock and pulse counters, with a ceiling on run length
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        n_start += (start_p === 1'b1);
        n_ack += (ack_p === 1'b1);
        n_coast += (coast_p === 1'b1);
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One command write through the master, then let the pipeline settle
    task automatic wr(input logic [15:0] w);
        @(posedge clk);
        #1;
        word = w;
        send = 1'b1;
        @(posedge clk);
        #1;
        send = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        check("open", brk_open, 1);
        check("pwr", pwr, dfcs_pkg::PWR_REDUCED);
        wr(16'h8400);
        check("rdata", cmd_rdata, 16'h8400);
        check("fbact", state_word[dfcs_pkg::SB_FB_ACT], 1);
        check("rsv", state_word & 16'h3800, 0);
        check("float", float_ref, 1);
        // Status flags from drive levels
        for (int i = 0; i < 4; i++) begin
            st_in = 8'(i * 8'h5B + 8'h25);
            repeat (3) @(posedge clk);
            #1;
            exp_s = {5'h00, st_in[0], 1'b0, st_in[1], st_in[6], 1'b0, ~st_in[3], st_in[5],
                st_in[7], st_in[2], 1'b0, ~st_in[7] & st_in[5] & ~st_in[4] & ~st_in[3]};
            check("status", state_word & 16'h05BD, exp_s);
        end
        st_in = 8'h00;
        // Power and droop both ways, floating reference disabled
        wr(16'h0470);
        check("float", float_ref, 0);
        check("droop", droop, 1);
        check("pwr", pwr, 16'h0BB8);
        wr(16'h0400);
        check("droop", droop, 0);
        check("pwr", pwr, dfcs_pkg::PWR_REDUCED);
        // Reference select codes and threshold boundary
        for (int s = 0; s < 4; s++) begin
            wr(16'h0400 | 16'(s << 8));
            check("ref", ref_out, s == 0 ? bus_ref : levels[s]);
        end
        bus_ref = 16'h1388;
        wr(16'h0400);
        check("ref", ref_out, 16'h1234);
        // Start on edge only, then coast stop on losing control
        st_in = 8'h04;
        wr(16'h0408);
        check("run", run, 1);
        check("start", 16'(n_start), 1);
        wr(16'h0408);
        check("start", 16'(n_start), 1);
        wr(16'h0000);
        check("coast", 16'(n_coast), 1);
        check("frozen", run, 1);
        check("fbact", state_word[dfcs_pkg::SB_FB_ACT], 0);
        wr(16'h0400);
        check("run", run, 0);
        st_in = 8'h00;
        // Fault acknowledge on edge only
        wr(16'h0480);
        wr(16'h0480);
        check("ack", 16'(n_ack), 1);
        // Precharge with forced restart lock and breaker closing
        dc_zero = 1'b0;
        wr(16'h0401);
        wr(16'h0405);
        check("pre", pre, 0);
        dc_zero = 1'b1;
        wr(16'h0405);
        check("pre", pre, 1);
        check("chg", state_word[dfcs_pkg::SB_CHARGING], 1);
        check("close", brk_close, 0);
        dc_ready = 1'b1;
        brk_fb = 1'b1;
        brk_int = 1'b1;
        wr(16'h0407);
        check("close", brk_close, 1);
        check("rdyrun", state_word[dfcs_pkg::SB_READY_RUN], 1);
        check("brkok", state_word[dfcs_pkg::SB_BRK_OK], 1);
        brk_int = 1'b0;
        wr(16'h0404);
        check("brkok", state_word[dfcs_pkg::SB_BRK_OK], 1);
        check("open", brk_open, 1);
        check("pre", pre, 0);
        check("rdyrun", state_word[dfcs_pkg::SB_READY_RUN], 0);
        place_bus = 1'b0;
        brk_int = 1'b1;
        local_start = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("pre", pre, 1);
        check("brkok", state_word[dfcs_pkg::SB_BRK_OK], 0);
        // Watchdog supervision and echo
        wd_set = 16'h0003;
        toggle_en = 1'b1;
        repeat (40) @(posedge clk);
        #1;
        check("wd", wd_fault, 0);
        toggle_en = 1'b0;
        repeat (30) @(posedge clk);
        #1;
        check("wd", wd_fault, 1);
        check("echo", state_word[dfcs_pkg::SB_ECHO], toggle_bit);
        wd_set = 16'h0000;
        wr(16'h0400);
        wr(16'h0480);
        check("wd", wd_fault, 0);
        end_of_test();
    end
endmodule
